// ### logic/hpa_params.svh
/*
 Offsets, field positions, reset values and bus constants of the pipe address and event block.
 Assumes inclusion by bare name from the design module.
*/
`ifndef HPA_PARAMS_SVH
`define HPA_PARAMS_SVH

`define HPA_OFF_ADDR      12'h424
`define HPA_OFF_STATUS    12'h500
`define HPA_OFF_CLEAR     12'h510
`define HPA_OFF_MASK      12'h520
`define HPA_OFF_FREEZE    12'h530
`define HPA_OFF_PIPE_MAX_PACKET_SIZE     12'h540

`define HPA_BIT_SHORT     7
`define HPA_BIT_STALL     6
`define HPA_BIT_OVERF     5

`define HPA_ADDR_W        7
`define HPA_ADDR_STRIDE   8
`define HPA_PIPE_MAX_PACKET_SIZE_W       11
`define HPA_PIPE_MAX_PACKET_SIZE_STRIDE  16

`define HPA_RST_ADDR      32'h0000_0000
`define HPA_RST_PIPE_MAX_PACKET_SIZE     11'h040

`endif

// ### logic/hpa_pkg.sv
/*
 Types shared by the pipe address and event block.
 Assumes the constants header is on the include path.
*/
package hpa_pkg;
	typedef logic [3:0]  hpa_pipe_t;
	typedef logic [31:0] hpa_word_t;
endpackage : hpa_pkg

// ### logic/hpa_pipe_addr_flags.sv
/*
 Host pipe target addresses and per-pipe receive event flags, APB slave.
 Assumes the pipe engine gives one-cycle event pulses and length reports on clk.
*/
`timescale 1ns/1ps
`include "hpa_params.svh"
module hpa_pipe_addr_flags
	import hpa_pkg::*;
#(
	parameter int NPIPE = 4
) (
	// Clock, reset, enable
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       clk_en,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Pipe engine events
	input  wire logic                       usb_reset_req,
	input  wire logic [NPIPE-1:0]           rx_done,
	input  wire logic [`HPA_PIPE_MAX_PACKET_SIZE_W-1:0]    rx_len,
	input  wire logic [1:0]                 rx_pipe,
	input  wire logic [NPIPE-1:0]           stall_rcvd,
	// Pipe state and interrupt
	output logic      [NPIPE-1:0]           pipe_frozen,
	output logic      [`HPA_ADDR_W*NPIPE-1:0] pipe_dev_addr,
	output logic                            irq
);

	logic [31:0]            host_pipe_target_address_r;
	logic [NPIPE-1:0]       short_pkt_flag_r;
	logic [NPIPE-1:0]       stall_rcvd_flag_r;
	logic [NPIPE-1:0]       pipe_overrun_flag_r;
	logic [NPIPE-1:0]       short_pkt_en_r;
	logic [NPIPE-1:0]       stall_rcvd_enable_r;
	logic [NPIPE-1:0]       pipe_overrun_enable_r;
	logic [NPIPE-1:0]       frozen_r;
	logic [`HPA_PIPE_MAX_PACKET_SIZE_W-1:0] pipe_max_packet_size_r [NPIPE];
	logic [31:0]            prdata_r;
	logic                   wr;
	logic                   rd;
	logic                   hit;
	logic [NPIPE-1:0]       clr_short;
	logic [NPIPE-1:0]       clr_stall;
	logic [NPIPE-1:0]       clr_overf;
	logic [NPIPE-1:0]       short_ev;
	logic [NPIPE-1:0]       overf_ev;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr      = psel && penable && pwrite && clk_en;
	assign rd      = psel && !penable && !pwrite;
	assign hit     = (paddr == `HPA_OFF_ADDR) || (paddr == `HPA_OFF_STATUS) ||
		(paddr == `HPA_OFF_CLEAR) || (paddr == `HPA_OFF_MASK) ||
		(paddr == `HPA_OFF_FREEZE) || (paddr == `HPA_OFF_PIPE_MAX_PACKET_SIZE) ||
		(paddr == `HPA_OFF_PIPE_MAX_PACKET_SIZE + 12'h004);
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_r;

	// Per-pipe event decode and write-one-to-clear strobes
	always_comb begin
		for (int i = 0; i < NPIPE; i++) begin
			clr_short[i] = wr && paddr == `HPA_OFF_CLEAR && pwdata[8*i+`HPA_BIT_SHORT];
			clr_stall[i] = wr && paddr == `HPA_OFF_CLEAR && pwdata[8*i+`HPA_BIT_STALL];
			clr_overf[i] = wr && paddr == `HPA_OFF_CLEAR && pwdata[8*i+`HPA_BIT_OVERF];
			short_ev[i]  = rx_done[i] && rx_pipe == 2'(i) && rx_len < pipe_max_packet_size_r[i];
			overf_ev[i]  = rx_done[i] && rx_pipe == 2'(i) && rx_len > pipe_max_packet_size_r[i];
		end
	end

	// Target addresses; bus reset request beats a software write
	always_ff @(posedge clk) begin
		if (reset) begin
			host_pipe_target_address_r <= `HPA_RST_ADDR;
		end else if (clk_en) begin
			if (usb_reset_req) begin
				host_pipe_target_address_r <= 32'h0000_0000;
			end else if (wr && paddr == `HPA_OFF_ADDR) begin
				host_pipe_target_address_r <= pwdata & 32'h7F7F_7F7F;
			end
		end
	end

	generate
		for (genvar g = 0; g < NPIPE; g++) begin : g_addr
			assign pipe_dev_addr[`HPA_ADDR_W*g +: `HPA_ADDR_W] =
				host_pipe_target_address_r[`HPA_ADDR_STRIDE*g +: `HPA_ADDR_W];
		end
	endgenerate

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			short_pkt_flag_r    <= '0;
			stall_rcvd_flag_r   <= '0;
			pipe_overrun_flag_r <= '0;
		end else if (clk_en) begin
			short_pkt_flag_r    <= (short_pkt_flag_r & ~clr_short) | short_ev;
			stall_rcvd_flag_r   <= (stall_rcvd_flag_r & ~clr_stall) | stall_rcvd;
			pipe_overrun_flag_r <= (pipe_overrun_flag_r & ~clr_overf) | overf_ev;
		end
	end

	// Freeze: set by a stall, released by writing zero to the freeze bit
	always_ff @(posedge clk) begin
		if (reset) begin
			frozen_r <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NPIPE; i++) begin
				if (stall_rcvd[i]) begin
					frozen_r[i] <= 1'b1;
				end else if (wr && paddr == `HPA_OFF_FREEZE) begin
					frozen_r[i] <= pwdata[i];
				end
			end
		end
	end
	assign pipe_frozen = frozen_r;

	// Mask enables and max packet sizes
	always_ff @(posedge clk) begin
		if (reset) begin
			short_pkt_en_r        <= '0;
			stall_rcvd_enable_r   <= '0;
			pipe_overrun_enable_r <= '0;
			for (int i = 0; i < NPIPE; i++) begin
				pipe_max_packet_size_r[i] <= `HPA_RST_PIPE_MAX_PACKET_SIZE;
			end
		end else if (clk_en && wr) begin
			if (paddr == `HPA_OFF_MASK) begin
				for (int i = 0; i < NPIPE; i++) begin
					short_pkt_en_r[i]        <= pwdata[8*i+`HPA_BIT_SHORT];
					stall_rcvd_enable_r[i]   <= pwdata[8*i+`HPA_BIT_STALL];
					pipe_overrun_enable_r[i] <= pwdata[8*i+`HPA_BIT_OVERF];
				end
			end
			for (int i = 0; i < NPIPE; i++) begin
				if (paddr == `HPA_OFF_PIPE_MAX_PACKET_SIZE + 12'(4*(i/2))) begin
					pipe_max_packet_size_r[i] <= pwdata[`HPA_PIPE_MAX_PACKET_SIZE_STRIDE*(i%2) +: `HPA_PIPE_MAX_PACKET_SIZE_W];
				end
			end
		end
	end

	// Level interrupt from unmasked flags
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |((stall_rcvd_flag_r & stall_rcvd_enable_r) |
				(pipe_overrun_flag_r & pipe_overrun_enable_r) |
				(short_pkt_flag_r & short_pkt_en_r));
		end
	end

	// Read data registered in setup so it is stable through the access cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_r <= 32'h0000_0000;
		end else if (clk_en && rd) begin
			prdata_r <= 32'h0000_0000;
			for (int i = 0; i < NPIPE; i++) begin
				unique case (paddr)
					`HPA_OFF_STATUS: begin
						prdata_r[8*i+`HPA_BIT_SHORT] <= short_pkt_flag_r[i];
						prdata_r[8*i+`HPA_BIT_STALL] <= stall_rcvd_flag_r[i];
						prdata_r[8*i+`HPA_BIT_OVERF] <= pipe_overrun_flag_r[i];
					end
					`HPA_OFF_MASK: begin
						prdata_r[8*i+`HPA_BIT_SHORT] <= short_pkt_en_r[i];
						prdata_r[8*i+`HPA_BIT_STALL] <= stall_rcvd_enable_r[i];
						prdata_r[8*i+`HPA_BIT_OVERF] <= pipe_overrun_enable_r[i];
					end
					`HPA_OFF_FREEZE: prdata_r[i] <= frozen_r[i];
					`HPA_OFF_ADDR: prdata_r[8*i +: 8] <= host_pipe_target_address_r[8*i +: 8];
					default: begin
						if (paddr == `HPA_OFF_PIPE_MAX_PACKET_SIZE + 12'(4*(i/2))) begin
							prdata_r[`HPA_PIPE_MAX_PACKET_SIZE_STRIDE*(i%2) +: `HPA_PIPE_MAX_PACKET_SIZE_W] <= pipe_max_packet_size_r[i];
						end
					end
				endcase
			end
		end
	end

endmodule : hpa_pipe_addr_flags

// ### sim/hpa_pipe_addr_flags_sva.sv
/* Checker for the pipe address and event block. Assumes a bind from the bench top. */
`timescale 1ns/1ps
module hpa_pipe_addr_flags_sva #(
	parameter int NPIPE = 4
) (
	// Clock and bus
	input wire logic                 clk, reset, clk_en, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	// Events and state
	input wire logic                 usb_reset_req, irq,
	input wire logic [NPIPE-1:0]     rx_done, stall_rcvd, pipe_frozen,
	input wire logic [7*NPIPE-1:0]   pipe_dev_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic        wr, wa, cause;
	logic [27:0] exp_addr_r;
	assign wr = psel && penable && pwrite && clk_en;
	assign wa = wr && paddr == 12'h424;
	assign cause = |stall_rcvd || |rx_done || wr;
	// Packing kept apart from the design so a swapped field shows at once
	always_ff @(posedge clk) exp_addr_r <= {pwdata[30:24], pwdata[22:16], pwdata[14:8], pwdata[6:0]};
	sequence stall_s;
		clk_en && |stall_rcvd;
	endsequence
	ready_now_a: assert property (psel && penable |-> pready) else $error("pready low");
	slverr_map_a: assert property (psel && penable |-> pslverr == !(paddr inside
		{12'h424, 12'h500, 12'h510, 12'h520, 12'h530, 12'h540, 12'h544})) else $error("pslverr");
	addr_write_a: assert property (wa && !usb_reset_req |=> pipe_dev_addr == exp_addr_r)
		else $error("address write");
	addr_clear_a: assert property (usb_reset_req && clk_en |=> pipe_dev_addr == '0)
		else $error("address not cleared");
	addr_hold_a: assert property (!wa && !(usb_reset_req && clk_en) |=> $stable(pipe_dev_addr))
		else $error("address changed");
	stall_freeze_a: assert property (stall_s |=>
		(pipe_frozen & $past(stall_rcvd)) == $past(stall_rcvd)) else $error("pipe not frozen");
	irq_source_a: assert property ($rose(irq) |-> $past(cause, 2)) else $error("irq cause");
	enable_hold_a: assert property (!clk_en |=> $stable(pipe_frozen) && $stable(irq))
		else $error("state moved");
endmodule : hpa_pipe_addr_flags_sva

// ### sim/hpa_usb_dev_model.sv
/* Attached device model giving packet and STALL pulses. Assumes clk from the bench. */
`timescale 1ns/1ps
module hpa_usb_dev_model (
	// Clock
	input wire logic    clk,
	// Pipe engine events
	output logic [3:0]  rx_done,
	output logic [3:0]  stall_rcvd,
	output logic [10:0] rx_len,
	output logic [1:0]  rx_pipe
);
	initial rx_done = '0;
	initial stall_rcvd = '0;
	initial rx_len = '0;
	initial rx_pipe = '0;
	task pkt(input logic [1:0] p, input logic [10:0] n);
		@(posedge clk);
		rx_done <= 4'h1 << p;
		rx_len <= n;
		rx_pipe <= p;
		@(posedge clk);
		rx_done <= '0;
		// Idle lines show the inverse, never a stale valid length
		rx_len <= ~n;
		rx_pipe <= ~p;
	endtask : pkt
	task stall(input logic [1:0] p);
		@(posedge clk);
		stall_rcvd <= 4'h1 << p;
		@(posedge clk);
		stall_rcvd <= '0;
	endtask : stall
endmodule : hpa_usb_dev_model

// ### sim/hpa_pipe_addr_flags_tb.sv
/* Bench for the pipe address and event block. Assumes design and model compiled first. */
`timescale 1ns/1ps
module hpa_pipe_addr_flags_tb;
	import hpa_pkg::*;
	typedef struct {logic [11:0] a; hpa_word_t d; hpa_word_t r; logic e;} hpa_row_s;
	logic        clk = 0, reset = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic        usb_reset_req = 0, pready, pslverr, irq, err;
	logic [11:0] paddr = '0;
	hpa_word_t   pwdata = '0, prdata, rd;
	logic [3:0]  rx_done, stall_rcvd, pipe_frozen;
	logic [10:0] rx_len;
	logic [1:0]  rx_pipe;
	logic [27:0] pipe_dev_addr;
	int          mismatches = 0, checked = 0, cyc = 0;
	// Distinct field values so a swapped or shifted address field shows
	hpa_row_s    rows[9] = '{'{12'h424, 32'h84838281, 32'h04030201, 0},
		'{12'h520, 32'h40404040, 32'h40404040, 0}, '{12'h530, 32'h5, 32'h5, 0},
		'{12'h530, 32'h0, 32'h0, 0}, '{12'h510, 32'hFFFFFFFF, 32'h0, 0},
		'{12'h7FC, 32'hFFFFFFFF, 32'h0, 1}, '{12'h520, 32'h0, 32'h0, 0},
		'{12'h540, 32'hFFFF0040, 32'h07FF0040, 0}, '{12'h544, 32'hF810F830, 32'h00100030, 0}};
	hpa_word_t   ev[3] = '{32'h40000000, 32'h00008000, 32'h00200000};
	logic [11:0] ra[3] = '{12'h424, 12'h540, 12'h544};
	hpa_word_t   rv[3] = '{32'h00000000, 32'h00400040, 32'h00400040};
	always #12.5 clk = ~clk;
	hpa_pipe_addr_flags i_hpa_pipe_addr_flags (.clk(clk), .reset(reset), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_reset_req(usb_reset_req),
		.rx_done(rx_done), .rx_len(rx_len), .rx_pipe(rx_pipe), .stall_rcvd(stall_rcvd),
		.pipe_frozen(pipe_frozen), .pipe_dev_addr(pipe_dev_addr), .irq(irq));
	hpa_usb_dev_model i_hpa_usb_dev_model (.clk(clk), .rx_done(rx_done),
		.stall_rcvd(stall_rcvd), .rx_len(rx_len), .rx_pipe(rx_pipe));
	task end_sim;
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	task cmp(input string n, input hpa_word_t e, input hpa_word_t g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task apb(input logic w, input logic [11:0] a, input hpa_word_t d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1;
		// Wait on pready itself; a slow slave must not be mistaken for done
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task irq_is(input logic e);
		repeat (2) @(posedge clk);
		#1 cmp("irq", e, irq);
	endtask : irq_is
	task rst_chk;
		foreach (ra[i]) begin
			apb(0, ra[i], 0);
			cmp("reset value", rv[i], rd);
		end
		cmp("reset frozen", 0, pipe_frozen);
		cmp("reset irq", 0, irq);
	endtask : rst_chk
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		rst_chk();
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			cmp("slave error", rows[i].e, err);
			apb(0, rows[i].a, 0);
			cmp("read back", rows[i].r, rd);
		end
		cmp("pipe addresses", 32'h0080C101, pipe_dev_addr);
		i_hpa_usb_dev_model.pkt(1, 11'h003);
		i_hpa_usb_dev_model.pkt(2, 11'h041);
		i_hpa_usb_dev_model.pkt(0, 11'h040);
		i_hpa_usb_dev_model.stall(3);
		apb(0, 12'h500, 0);
		cmp("status", 32'h40208000, rd);
		cmp("frozen", 4'h8, pipe_frozen);
		cmp("masked irq", 0, irq);
		foreach (ev[i]) begin
			apb(1, 12'h520, ev[i]);
			irq_is(1);
			apb(1, 12'h510, ev[i]);
			irq_is(0);
		end
		apb(1, 12'h530, 0);
		@(posedge clk);
		cmp("unfrozen", 0, pipe_frozen);
		usb_reset_req <= 1;
		@(posedge clk);
		usb_reset_req <= 0;
		apb(0, 12'h424, 0);
		cmp("bus reset address", 0, rd);
		cmp("bus reset pins", 0, pipe_dev_addr);
		clk_en <= 0;
		apb(1, 12'h424, 32'h01010101);
		clk_en <= 1;
		apb(0, 12'h424, 0);
		cmp("write while halted", 0, rd);
		// Mid-run reset with a pending unmasked flag and all pipes frozen
		i_hpa_usb_dev_model.pkt(2, 11'h041);
		apb(1, 12'h530, 32'h0000000F);
		irq_is(1);
		@(posedge clk);
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		rst_chk();
		end_sim();
	end
endmodule : hpa_pipe_addr_flags_tb
bind hpa_pipe_addr_flags hpa_pipe_addr_flags_sva #(.NPIPE(NPIPE)) i_hpa_pipe_addr_flags_sva (
	.clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
	.usb_reset_req(usb_reset_req), .irq(irq), .rx_done(rx_done), .stall_rcvd(stall_rcvd),
	.pipe_frozen(pipe_frozen), .pipe_dev_addr(pipe_dev_addr));
